// ### hdl/hs_ctrl.sv
// Secondary port hot-swap controller with APB register file
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module hs_ctrl
    import hs_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_CYC
)
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output      logic               pready,
    output      logic [31:0]        prdata,
    output      logic               pslverr,
    // Card and strap pins
    input  wire logic               port_a_removal_notice,
    input  wire logic               port_b_removal_notice,
    input  wire logic [NPORT-1:0]   strap_pcix,
    input  wire logic [NPORT-1:0]   pll_locked,
    input  wire logic               later_revision_mode,
    // Bridge core
    input  wire hs_core_in_s        core_in  [NPORT],
    output      hs_core_out_s       core_out [NPORT],
    // Port PLL and mode
    output      logic [FREQ_W-1:0]  pll_freq_sel [NPORT],
    output      logic [NPORT-1:0]   port_pcix_mode,
    // Interrupt
    output      logic               irq
);

    localparam logic [LOCK_CNT_W-1:0]  LOCK_LOAD  = LOCK_CNT_W'(LOCK_CYCLES);
    localparam logic [FLUSH_CNT_W-1:0] FLUSH_LAST = FLUSH_CNT_W'(FLUSH_CYC - PIN_LAT - 1);

    hs_state_s          st_reg;
    hs_state_s          st_next;
    logic [SYNC_W-1:0]  pin_raw;
    logic [SYNC_W-1:0]  pin_q;
    logic               bus_setup;
    logic               bus_access;
    logic               bus_wr;
    logic               addr_hit;
    logic [EV_W-1:0]    ev_set;
    logic [EV_W-1:0]    ev_clr;
    logic [31:0]        status_word;
    logic [31:0]        rd_word;
    logic [7:0]         ctrl_addr;
    logic               notice;
    logic               strap;
    logic               lock_in;
    logic               later;
    logic               locked_now;
    logic               drained;

    // Pins arrive from outside the clock domain
    assign pin_raw = {later_revision_mode, pll_locked, strap_pcix,
                      port_b_removal_notice, port_a_removal_notice};

    hs_sync3 u_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .async_in (pin_raw),
        .sync_out (pin_q)
    );

    assign bus_setup  = psel & ~penable;
    assign bus_access = psel & penable;
    assign bus_wr     = bus_access & pwrite;

    // Register decode
    always_comb
    begin
        addr_hit = (paddr == ADDR_CTRL_A) || (paddr == ADDR_CTRL_B) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT) ||
                   (paddr == ADDR_IRQ_MASK);
    end

    // Status word built from live port state
    always_comb
    begin
        status_word = ZERO_WORD;
        for (int p = 0; p < NPORT; p++)
        begin
            status_word[p*STAT_PER_PORT+STAT_QUIESCE] = st_reg.port[p].state != HS_RUN;
            status_word[p*STAT_PER_PORT+STAT_FLUSHED] = st_reg.port[p].flushed;
            status_word[p*STAT_PER_PORT+STAT_INRST]   = st_reg.port[p].state == HS_RESET;
            status_word[p*STAT_PER_PORT+STAT_LOCKED]  = st_reg.port[p].lock_ok;
            status_word[p*STAT_PER_PORT+STAT_PCIX]    = st_reg.port[p].pcix;
            status_word[p*STAT_PER_PORT+STAT_PARKED]  = core_out[p].req_park;
            status_word[p*STAT_PER_PORT+STAT_NOTICE]  = pin_q[SY_NOTICE+p];
        end
    end

    // Read mux, sampled in the setup cycle
    always_comb
    begin
        rd_word = ZERO_WORD;
        unique case (paddr)
            ADDR_CTRL_A:
            begin
                rd_word[CTRL_RST_BIT]              = st_reg.port[0].rst_bit;
                rd_word[FREQ_LSB +: FREQ_W]        = st_reg.port[0].freq;
            end
            ADDR_CTRL_B:
            begin
                rd_word[CTRL_RST_BIT]              = st_reg.port[1].rst_bit;
                rd_word[FREQ_LSB +: FREQ_W]        = st_reg.port[1].freq;
            end
            ADDR_STATUS:   rd_word = status_word;
            ADDR_IRQ_STAT: rd_word[EV_W-1:0] = st_reg.irq_stat;
            ADDR_IRQ_MASK: rd_word[EV_W-1:0] = st_reg.irq_mask;
            default:       rd_word = ZERO_WORD;
        endcase
    end

    // Next state of the whole controller
    always_comb
    begin
        st_next    = st_reg;
        ev_set     = '0;
        ev_clr     = '0;
        ctrl_addr  = ADDR_CTRL_A;
        notice     = 1'b0;
        strap      = 1'b0;
        lock_in    = 1'b0;
        locked_now = 1'b0;
        drained    = 1'b0;
        later      = pin_q[SY_LATER];
        st_next.init = 1'b1;

        for (int p = 0; p < NPORT; p++)
        begin
            ctrl_addr = (p == 0) ? ADDR_CTRL_A : ADDR_CTRL_B;
            notice    = pin_q[SY_NOTICE+p];
            strap     = pin_q[SY_STRAP+p];
            lock_in   = pin_q[SY_LOCK+p];
            st_next.port[p].rd_valid = 1'b0;

            // Zero-data answer one cycle after the request
            if (st_reg.port[p].state != HS_RUN && core_in[p].hl_rd_valid)
            begin
                st_next.port[p].rd_valid = 1'b1;
                st_next.port[p].rd_data  = ZERO_WORD;
            end

            // Software control write; frequency only while held in reset
            if (bus_wr && paddr == ctrl_addr)
            begin
                st_next.port[p].rst_bit = pwdata[CTRL_RST_BIT];
                if (later && st_reg.port[p].rst_bit &&
                    pwdata[FREQ_LSB +: FREQ_W] != st_reg.port[p].freq)
                begin
                    st_next.port[p].freq     = pwdata[FREQ_LSB +: FREQ_W];
                    st_next.port[p].lock_cnt = LOCK_LOAD;
                end
            end
            else if (st_reg.port[p].lock_cnt != '0)
            begin
                st_next.port[p].lock_cnt = st_reg.port[p].lock_cnt - 1'b1;
            end

            // Lock is only believed once the wait has run out
            locked_now = (st_next.port[p].lock_cnt == '0) && lock_in;
            st_next.port[p].lock_ok = locked_now;
            if (locked_now && !st_reg.port[p].lock_ok)
            begin
                ev_set[p*EV_PER_PORT+EV_LOCKED] = 1'b1;
            end

            // Mode strap: first value after reset, later only in port reset
            if (!st_reg.init)
            begin
                st_next.port[p].pcix = strap;
            end
            else if (st_reg.port[p].state == HS_RESET && later)
            begin
                st_next.port[p].pcix = strap;
            end

            drained = !core_in[p].p2h_wr_pending && !core_in[p].p2h_rd_outstanding;

            if (st_next.port[p].rst_bit && st_reg.port[p].state != HS_RESET)
            begin
                st_next.port[p].state = HS_RESET;
            end
            else
            begin
                unique case (st_reg.port[p].state)
                    HS_RUN:
                    begin
                        if (notice)
                        begin
                            ev_set[p*EV_PER_PORT+EV_NOTICE] = 1'b1;
                            st_next.port[p].flush_cnt = '0;
                            st_next.port[p].flushed   = 1'b0;
                            st_next.port[p].state     = HS_FINISH;
                        end
                    end
                    HS_FINISH, HS_FLUSH:
                    begin
                        st_next.port[p].flush_cnt = st_reg.port[p].flush_cnt + 1'b1;
                        if (st_reg.port[p].state == HS_FINISH && !core_in[p].pci_busy)
                        begin
                            st_next.port[p].state = HS_FLUSH;
                        end
                        else if (st_reg.port[p].state == HS_FLUSH && drained)
                        begin
                            st_next.port[p].flushed = 1'b1;
                            st_next.port[p].state   = HS_QUIET;
                            ev_set[p*EV_PER_PORT+EV_FLUSHED] = 1'b1;
                        end
                        // A stuck bus must not hold the host past the deadline
                        if (st_next.port[p].state != HS_QUIET &&
                            st_reg.port[p].flush_cnt >= FLUSH_LAST)
                        begin
                            st_next.port[p].state = HS_QUIET;
                            ev_set[p*EV_PER_PORT+EV_TIMEOUT] = 1'b1;
                        end
                    end
                    HS_QUIET:
                    begin
                        st_next.port[p].state = HS_QUIET;
                    end
                    HS_RESET:
                    begin
                        if (!st_next.port[p].rst_bit)
                        begin
                            st_next.port[p].flushed = 1'b0;
                            st_next.port[p].state   = HS_RUN;
                        end
                    end
                endcase
            end
        end

        // Interrupt mask and write-one-to-clear status
        if (bus_wr && paddr == ADDR_IRQ_MASK)
        begin
            st_next.irq_mask = pwdata[EV_W-1:0];
        end
        if (bus_wr && paddr == ADDR_IRQ_STAT)
        begin
            ev_clr = pwdata[EV_W-1:0];
        end
        // Set beats clear so no event is lost
        st_next.irq_stat = (st_reg.irq_stat & ~ev_clr) | ev_set;

        if (bus_setup)
        begin
            st_next.prdata = rd_word;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // APB answer: zero wait states
    assign pready  = bus_access;
    assign pslverr = bus_access & ~addr_hit;
    assign prdata  = st_reg.prdata;
    assign irq     = |(st_reg.irq_stat & st_reg.irq_mask);

    // Per-port outputs towards the bridge core
    generate
        for (genvar g = 0; g < NPORT; g++)
        begin : g_port
            logic quiet;
            logic parked;
            assign quiet  = st_reg.port[g].state != HS_RUN;
            assign parked = st_reg.port[g].state == HS_FLUSH ||
                            st_reg.port[g].state == HS_QUIET;
            assign core_out[g].req_park         = parked;
            assign core_out[g].start_inhibit    = quiet;
            assign core_out[g].hl_wr_drop       = quiet & core_in[g].hl_wr_valid;
            assign core_out[g].hl_rd_accept     = quiet & core_in[g].hl_rd_valid;
            assign core_out[g].hl_rd_zero_valid = st_reg.port[g].rd_valid;
            assign core_out[g].hl_rd_zero_data  = st_reg.port[g].rd_data;
            assign core_out[g].p2h_wr_flush     = quiet;
            assign core_out[g].p2h_rd_discard   = quiet;
            assign core_out[g].bus_rst_n        = ~st_reg.port[g].rst_bit;
            // Any value in range goes to the PLL; field only picks the band
            assign pll_freq_sel[g]              = st_reg.port[g].freq;
            assign port_pcix_mode[g]            = st_reg.port[g].pcix;
        end
    endgenerate

endmodule : hs_ctrl

// ### hdl/hs_pkg.sv
// Constants, types and carriers for the secondary port hot-swap controller
package hs_pkg;

    // Ports and clock
    localparam int NPORT        = 2;
    localparam int CLK_HZ       = 10_000_000;

    // Flush deadline: longest time, rounded down
    localparam int FLUSH_US     = 40;
    localparam int FLUSH_CYC    = (FLUSH_US * (CLK_HZ / 1000)) / 1000;
    localparam int FLUSH_CNT_W  = 9;
    // Pin synchroniser and entry edge eat into the deadline
    localparam int PIN_LAT      = 5;

    // Port PLL lock wait: least time, rounded up
    localparam int LOCK_MS      = 5;
    localparam int LOCK_CYC     = (LOCK_MS * (CLK_HZ / 1000) + 0) / 1;
    localparam int LOCK_CNT_W   = 16;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // Control register fields
    localparam int CTRL_RST_BIT = 6;
    localparam int FREQ_LSB     = 2;
    localparam int FREQ_W       = 2;

    // Reset values
    localparam logic              RST_BIT_RST = 1'b0;
    localparam logic [FREQ_W-1:0] FREQ_RST    = 2'h0;
    localparam logic [7:0]        MASK_RST    = 8'h00;
    localparam logic [31:0]       ZERO_WORD   = 32'h0000_0000;

    // Interrupt event bits, per port group
    localparam int EV_PER_PORT  = 4;
    localparam int EV_NOTICE    = 0;
    localparam int EV_FLUSHED   = 1;
    localparam int EV_TIMEOUT   = 2;
    localparam int EV_LOCKED    = 3;
    localparam int EV_W         = NPORT * EV_PER_PORT;

    // Status register bits, per port byte
    localparam int STAT_PER_PORT = 8;
    localparam int STAT_QUIESCE  = 0;
    localparam int STAT_FLUSHED  = 1;
    localparam int STAT_INRST    = 2;
    localparam int STAT_LOCKED   = 3;
    localparam int STAT_PCIX     = 4;
    localparam int STAT_PARKED   = 5;
    localparam int STAT_NOTICE   = 6;

    // Synchroniser bit layout
    localparam int SY_NOTICE    = 0;
    localparam int SY_STRAP     = 2;
    localparam int SY_LOCK      = 4;
    localparam int SY_LATER     = 6;
    localparam int SYNC_W       = 7;

    // Per-port removal sequence
    typedef enum logic [2:0] {
        HS_RUN,
        HS_FINISH,
        HS_FLUSH,
        HS_QUIET,
        HS_RESET
    } hs_state_e;

    // Bridge core towards this block, per port
    typedef struct packed {
        logic pci_busy;
        logic hl_wr_valid;
        logic hl_rd_valid;
        logic p2h_wr_pending;
        logic p2h_rd_outstanding;
    } hs_core_in_s;

    // This block towards the bridge core, per port
    typedef struct packed {
        logic        req_park;
        logic        start_inhibit;
        logic        hl_wr_drop;
        logic        hl_rd_accept;
        logic        hl_rd_zero_valid;
        logic [31:0] hl_rd_zero_data;
        logic        p2h_wr_flush;
        logic        p2h_rd_discard;
        logic        bus_rst_n;
    } hs_core_out_s;

    // State held for one port
    typedef struct packed {
        hs_state_e              state;
        logic                   rst_bit;
        logic [FREQ_W-1:0]      freq;
        logic                   pcix;
        logic                   flushed;
        logic [FLUSH_CNT_W-1:0] flush_cnt;
        logic [LOCK_CNT_W-1:0]  lock_cnt;
        logic                   lock_ok;
        logic                   rd_valid;
        logic [31:0]            rd_data;
    } hs_port_s;

    // Whole controller state
    typedef struct packed {
        hs_port_s [NPORT-1:0] port;
        logic                 init;
        logic [EV_W-1:0]      irq_stat;
        logic [EV_W-1:0]      irq_mask;
        logic [31:0]          prdata;
    } hs_state_s;

    // Three-stage synchroniser state
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] q;
    } hs_sync_s;

endpackage : hs_pkg

// ### hdl/hs_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module hs_sync3
    import hs_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // Asynchronous inputs and their clean copy
    input  wire logic [SYNC_W-1:0] async_in,
    output      logic [SYNC_W-1:0] sync_out
);

    hs_sync_s st_reg;
    hs_sync_s st_next;

    // Out of reset, output only moves once stages two and three agree
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < SYNC_W; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
        // Follow the pins in reset so straps are valid at release
        if (!nrst)
        begin
            st_next.q = st_reg.s3;
        end
    end

    // No clear in reset: a cleared stage would hide the strap at release
    always_ff @(posedge sys_clk)
    begin
        st_reg <= st_next;
    end

    assign sync_out = st_reg.q;

endmodule : hs_sync3

// ### verification/hs_card_model.sv
// Card and host-link model facing the bridge core side of the controller
`timescale 1ns/1ns
module hs_card_model
    import hs_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Bench commands
    input  wire logic [NPORT-1:0] card_busy,
    input  wire logic [NPORT-1:0] host_wr,
    input  wire logic [NPORT-1:0] host_rd,
    // Core side
    input  wire hs_core_out_s     core_out [NPORT],
    output      hs_core_in_s      core_in  [NPORT]
);
    logic [2:0] drain_reg [NPORT];

    // Traffic never empties while running, so only a flush drains it
    always_ff @(posedge sys_clk)
    begin
        for (int p = 0; p < NPORT; p++)
            if (!nrst || !core_out[p].p2h_wr_flush)
                drain_reg[p] <= 3'h7;
            else if (drain_reg[p] != 3'h0)
                drain_reg[p] <= drain_reg[p] - 3'h1;
    end

    always_comb
    begin
        for (int p = 0; p < NPORT; p++)
        begin
            core_in[p].pci_busy           = card_busy[p];
            core_in[p].hl_wr_valid        = host_wr[p];
            core_in[p].hl_rd_valid        = host_rd[p];
            core_in[p].p2h_wr_pending     = drain_reg[p] > 3'h4;
            core_in[p].p2h_rd_outstanding = drain_reg[p] != 3'h0;
        end
    end
endmodule : hs_card_model

// ### verification/hs_ctrl_checker.sv
// Port-level assertions for the hot-swap controller
`timescale 1ns/1ns
module hs_ctrl_checker
    import hs_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_CYC
)
(
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              nrst,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    // Pins, core, PLL
    input wire logic              port_b_removal_notice,
    input wire hs_core_in_s       core_in  [NPORT],
    input wire hs_core_out_s      core_out [NPORT],
    input wire logic [FREQ_W-1:0] pll_freq_sel [NPORT],
    input wire logic [NPORT-1:0]  port_pcix_mode
);
    localparam int FLUSH_MAX = 402;
    logic       wr_a;
    logic       wr_b;
    logic       inh0;
    logic       park0;
    logic       rstn0;
    logic [3:0] b_seen;

    assign wr_a  = psel && penable && pwrite && paddr == ADDR_CTRL_A;
    assign wr_b  = psel && penable && pwrite && paddr == ADDR_CTRL_B;
    assign inh0  = core_out[0].start_inhibit;
    assign park0 = core_out[0].req_park;
    assign rstn0 = core_out[0].bus_rst_n;

    // Notice pin seen lately; covers the synchroniser delay
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            b_seen <= 4'h0;
        else if (port_b_removal_notice)
            b_seen <= 4'h8;
        else if (b_seen != 4'h0)
            b_seen <= b_seen - 4'h1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_rd_ask;
        core_in[0].hl_rd_valid && inh0;
    endsequence
    sequence s_zero_ans;
        core_out[0].hl_rd_zero_valid && core_out[0].hl_rd_zero_data == ZERO_WORD;
    endsequence

    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("pready missing in access cycle");
    a_write_drop: assert property (
        inh0 && core_in[0].hl_wr_valid |-> core_out[0].hl_wr_drop)
        else $error("host write not dropped");
    a_read_zero: assert property (s_rd_ask |-> core_out[0].hl_rd_accept ##1 s_zero_ans)
        else $error("host read not answered with zero");
    a_park_quiet: assert property (park0 |-> inh0)
        else $error("parked without start inhibit");
    a_finish_first: assert property (
        inh0 && !park0 && core_in[0].pci_busy && rstn0 |=> !park0)
        else $error("parked while transaction running");
    a_drain_levels: assert property (
        inh0 |-> core_out[0].p2h_wr_flush && core_out[0].p2h_rd_discard)
        else $error("pending traffic not discarded");
    a_flush_bound: assert property (
        $rose(inh0) && rstn0 |-> ##[0:FLUSH_MAX] (park0 || !rstn0))
        else $error("flush not finished in time");
    a_rst_set: assert property (wr_a && pwdata[CTRL_RST_BIT] |-> ##[1:2] !rstn0)
        else $error("bus reset not asserted");
    a_rst_clear: assert property (wr_a && !pwdata[CTRL_RST_BIT] |-> ##[1:2] rstn0)
        else $error("bus reset not released");
    a_freq_gate: assert property (
        $changed(pll_freq_sel[0]) |-> $past(wr_a) && !$past(rstn0))
        else $error("frequency changed outside reset write");
    a_mode_gate: assert property (
        $changed(port_pcix_mode[0]) && $past(nrst, 3) |-> !$past(rstn0) || !rstn0)
        else $error("mode changed outside reset");
    a_port_indep: assert property (
        $rose(core_out[1].start_inhibit) |-> b_seen != 4'h0 || $past(wr_b))
        else $error("port b quiesced without its notice");
endmodule : hs_ctrl_checker

bind hs_ctrl hs_ctrl_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .port_b_removal_notice(port_b_removal_notice), .core_in(core_in), .core_out(core_out),
    .pll_freq_sel(pll_freq_sel), .port_pcix_mode(port_pcix_mode)
);

// ### verification/tb_top.sv
// Self-checking bench for the hot-swap controller
`timescale 1ns/1ns
module tb_top
    import hs_pkg::*;
;
    localparam int LOCKS = 20;
    logic              sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err, irq;
    logic              notice_a, notice_b, later;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [NPORT-1:0]  strap, locked, card_busy, host_wr, host_rd, pcix;
    logic [FREQ_W-1:0] freq_sel [NPORT];
    hs_core_in_s       core_in  [NPORT];
    hs_core_out_s      core_out [NPORT];
    int                miscompares, checked;

    always #50 sys_clk = ~sys_clk;

    hs_ctrl #(.LOCK_CYCLES(LOCKS)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .port_a_removal_notice(notice_a), .port_b_removal_notice(notice_b),
        .strap_pcix(strap), .pll_locked(locked), .later_revision_mode(later),
        .core_in(core_in), .core_out(core_out), .pll_freq_sel(freq_sel),
        .port_pcix_mode(pcix), .irq(irq)
    );

    hs_card_model i_card (
        .sys_clk(sys_clk), .nrst(nrst), .card_busy(card_busy), .host_wr(host_wr),
        .host_rd(host_rd), .core_out(core_out), .core_in(core_in)
    );

    task automatic give_verdict;
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1)
        begin
            miscompares++;
            give_verdict();
        end
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, ZERO_WORD);
        chk(rd, exp);
    endtask : rdchk

    function automatic logic flag(input int sel);
        case (sel)
            0: return core_out[0].start_inhibit;
            1: return core_out[0].req_park;
            2: return core_out[1].req_park;
            default: return irq;
        endcase
    endfunction : flag

    // Bounded wait on a design output
    task automatic wait_flag(input int sel);
        int n;
        n = 0;
        while (flag(sel) !== 1'b1 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (flag(sel) !== 1'b1)
        begin
            miscompares++;
            give_verdict();
        end
    endtask : wait_flag

    initial
    begin
        {sys_clk, nrst, psel, penable, pwrite, notice_a, notice_b, paddr, pwdata} = '0;
        {strap, locked, card_busy, host_wr, host_rd} = '0;
        later = 1'b1;
        miscompares = 0;
        checked = 0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        rdchk(ADDR_CTRL_A, ZERO_WORD);
        rdchk(ADDR_IRQ_MASK, ZERO_WORD);
        rdchk(ADDR_STATUS, ZERO_WORD);
        apb(1'b0, 8'h20, ZERO_WORD);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
        // Port A leaves while a transaction still runs
        card_busy <= 2'b01;
        notice_a <= 1'b1;
        wait_flag(0);
        repeat (3) @(negedge sys_clk);
        chk(core_out[0].req_park, 1'b0);
        chk(core_out[1].start_inhibit, 1'b0);
        @(posedge sys_clk);
        card_busy <= 2'b00;
        wait_flag(1);
        chk(core_out[0].start_inhibit, 1'b1);
        @(posedge sys_clk);
        host_wr <= 2'b01;
        @(negedge sys_clk);
        chk(core_out[0].hl_wr_drop, 1'b1);
        @(posedge sys_clk);
        host_wr <= 2'b00;
        host_rd <= 2'b01;
        @(negedge sys_clk);
        chk(core_out[0].hl_rd_accept, 1'b1);
        @(posedge sys_clk);
        host_rd <= 2'b00;
        @(negedge sys_clk);
        chk(core_out[0].hl_rd_zero_valid, 1'b1);
        chk(core_out[0].hl_rd_zero_data, ZERO_WORD);
        wait_flag(3);
        rdchk(ADDR_IRQ_STAT, 32'h0000_0003);
        apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0003);
        @(negedge sys_clk);
        chk(irq, 1'b0);
        // Port reset, card swap, new mode and frequency
        apb(1'b1, ADDR_CTRL_A, 32'h0000_0040);
        repeat (2) @(negedge sys_clk);
        chk(core_out[0].bus_rst_n, 1'b0);
        @(posedge sys_clk);
        notice_a <= 1'b0;
        strap <= 2'b01;
        // Lock already held, so only the wait can keep status low
        locked <= 2'b11;
        repeat (10) @(negedge sys_clk);
        chk(pcix, 2'b01);
        apb(1'b1, ADDR_CTRL_A, 32'h0000_004C);
        @(negedge sys_clk);
        chk(freq_sel[0], 2'h3);
        apb(1'b0, ADDR_STATUS, ZERO_WORD);
        chk(rd[STAT_LOCKED], 1'b0);
        repeat (LOCKS + 10) @(posedge sys_clk);
        apb(1'b0, ADDR_STATUS, ZERO_WORD);
        chk(rd[STAT_LOCKED], 1'b1);
        apb(1'b1, ADDR_CTRL_A, 32'h0000_000C);
        repeat (2) @(negedge sys_clk);
        chk(core_out[0].bus_rst_n, 1'b1);
        chk(core_out[0].start_inhibit, 1'b0);
        @(posedge sys_clk);
        strap <= 2'b00;
        repeat (10) @(negedge sys_clk);
        chk(pcix, 2'b01);
        apb(1'b1, ADDR_IRQ_STAT, 32'h0000_00FF);
        // Port B without the later revision mode keeps mode and frequency
        later <= 1'b0;
        apb(1'b1, ADDR_CTRL_B, 32'h0000_0040);
        apb(1'b1, ADDR_CTRL_B, 32'h0000_0048);
        strap <= 2'b10;
        repeat (10) @(negedge sys_clk);
        chk(freq_sel[1], 2'h0);
        chk(pcix, 2'b01);
        apb(1'b1, ADDR_CTRL_B, ZERO_WORD);
        // Port B bus never frees: forced quiet at the deadline
        card_busy <= 2'b10;
        notice_b <= 1'b1;
        wait_flag(2);
        rdchk(ADDR_IRQ_STAT, 32'h0000_0050);
        chk(irq, 1'b0);
        give_verdict();
    end
endmodule : tb_top
